// ### spd_pkg.sv
package spd_pkg;

  localparam int        CLK_PERIOD_NS  = 20;
  localparam int        LINK_PERIOD_NS = 125;
  // half period rounds down, so the made link clock is never slower than asked
  localparam int        LINK_HALF_CYC  = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;

  localparam int        KEY_BYTES      = 8;
  localparam logic [63:0] PROG_KEY     = 64'h1289ab45cdd888ff;

  localparam logic [7:0] OP_LOAD       = 8'h20;
  localparam logic [7:0] OP_LOAD_INC   = 8'h24;
  localparam logic [7:0] OP_STORE      = 8'h60;
  localparam logic [7:0] OP_STORE_INC  = 8'h64;
  localparam logic [7:0] OP_PTR_MASK   = 8'hfe;
  localparam logic [7:0] OP_PTR        = 8'h68;
  localparam logic [7:0] OP_IO_MASK    = 8'h90;
  localparam logic [7:0] OP_IO_READ    = 8'h10;
  localparam logic [7:0] OP_IO_WRITE   = 8'h90;
  localparam logic [7:0] OP_CS_MASK    = 8'hf0;
  localparam logic [7:0] OP_CS_READ    = 8'h80;
  localparam logic [7:0] OP_CS_WRITE   = 8'hc0;
  localparam logic [7:0] OP_KEY        = 8'he0;
  localparam int        OP_INC_BIT     = 2;

  localparam logic [3:0] CSS_STATUS    = 4'h0;
  localparam logic [3:0] CSS_PHY_CTRL  = 4'h2;
  localparam logic [3:0] CSS_IDENT     = 4'hf;
  localparam int        MPE_BIT        = 1;
  localparam logic [2:0] GUARD_RESET   = 3'h0;
  // identification value is arbitrary
  localparam logic [7:0] IDENT_DEFAULT = 8'h5a;

  typedef enum logic [3:0] {
    K_LOAD, K_STORE, K_PTR, K_IO_RD, K_IO_WR, K_CS_RD, K_CS_WR, K_KEY, K_BAD
  } spd_kind_type;

  function automatic spd_kind_type spd_decode(input logic [7:0] op);
    if (op == OP_LOAD || op == OP_LOAD_INC) return K_LOAD;
    if (op == OP_STORE || op == OP_STORE_INC) return K_STORE;
    if ((op & OP_PTR_MASK) == OP_PTR) return K_PTR;
    if ((op & OP_IO_MASK) == OP_IO_READ) return K_IO_RD;
    if ((op & OP_IO_MASK) == OP_IO_WRITE) return K_IO_WR;
    if ((op & OP_CS_MASK) == OP_CS_READ) return K_CS_RD;
    if ((op & OP_CS_MASK) == OP_CS_WRITE) return K_CS_WR;
    if (op == OP_KEY) return K_KEY;
    return K_BAD;
  endfunction

  function automatic logic spd_is_read(input spd_kind_type k);
    return k == K_LOAD || k == K_IO_RD || k == K_CS_RD;
  endfunction

endpackage

// ### spd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface spd_link_if;
  logic       link_clk;
  logic       h_valid;
  logic [7:0] h_data;
  logic       h_break;
  logic       d_valid;
  logic [7:0] d_data;

  modport dev (
    input  link_clk,
    input  h_valid,
    input  h_data,
    input  h_break,
    output d_valid,
    output d_data
  );

  modport host (
    output link_clk,
    output h_valid,
    output h_data,
    output h_break,
    input  d_valid,
    input  d_data
  );
endinterface
`default_nettype wire

// ### spd_link_div.sv
`timescale 1ns/1ns
`default_nettype none
module spd_link_div
  import spd_pkg::*;
#(
  parameter int HALF = LINK_HALF_CYC
) (
  input  wire logic mclk,
  input  wire logic rstn,
  output logic      link_clk,
  output logic      fall_tick
);
  if (HALF < 2 || HALF > 65536) begin : g_half_check
    $error("link half period must be two to 65536 clocks");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        clk;
  } spd_div_type;

  spd_div_type s;
  spd_div_type next_s;

  always_comb begin
    next_s = s;
    if (s.cnt == 16'(HALF - 1)) begin
      next_s.cnt = 16'h0;
      next_s.clk = ~s.clk;
    end else begin
      next_s.cnt = s.cnt + 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link_clk  = s.clk;
  // host changes its link outputs with the falling edge, half a period away from sampling
  assign fall_tick = s.clk && s.cnt == 16'(HALF - 1);
endmodule
`default_nettype wire

// ### spd_host.sv
`timescale 1ns/1ns
`default_nettype none
module spd_host
  import spd_pkg::*;
#(
  parameter int POLL_MAX = 16
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  spd_link_if.host         link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_break,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [7:0]  cmd_operand,
  input  wire logic [63:0] cmd_key,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             done
);
  if (POLL_MAX < 1 || POLL_MAX > 255) begin : g_poll_check
    $error("poll limit out of range");
  end

  typedef enum {H_IDLE, H_BRK, H_OP, H_OPND, H_KEY, H_POLL, H_WAIT} spd_hstate_type;

  typedef struct packed {
    spd_hstate_type st;
    logic [7:0]     op;
    logic [7:0]     operand;
    logic [63:0]    key;
    logic [2:0]     kcnt;
    logic           poll;
    logic [7:0]     pcnt;
    logic           h_valid;
    logic [7:0]     h_data;
    logic           h_break;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
    logic           done;
  } spd_host_type;

  spd_host_type s;
  spd_host_type next_s;
  logic         tick;

  spd_link_div u_div (
    .mclk      (mclk),
    .rstn      (rstn),
    .link_clk  (link.link_clk),
    .fall_tick (tick)
  );

  always_comb begin
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    next_s.done      = 1'b0;
    if (tick) begin
      next_s.h_valid = 1'b0;
      next_s.h_break = 1'b0;
    end
    unique case (s.st)
      H_IDLE: begin
        if (cmd_valid) begin
          next_s.op      = cmd_opcode;
          next_s.operand = cmd_operand;
          next_s.key     = cmd_key;
          next_s.kcnt    = 3'h0;
          next_s.poll    = 1'b0;
          next_s.pcnt    = 8'h0;
          next_s.st      = cmd_break ? H_BRK : H_OP;
        end
      end
      H_BRK: if (tick) begin
        next_s.h_break = 1'b1;
        next_s.done    = 1'b1;
        next_s.st      = H_IDLE;
      end
      H_OP: if (tick) begin
        next_s.h_valid = 1'b1;
        next_s.h_data  = s.op;
        if (spd_is_read(spd_decode(s.op))) begin
          next_s.st = H_WAIT;
        end else if (spd_decode(s.op) == K_KEY) begin
          next_s.st = H_KEY;
        end else begin
          next_s.st = H_OPND;
        end
      end
      H_OPND: if (tick) begin
        next_s.h_valid = 1'b1;
        next_s.h_data  = s.operand;
        next_s.done    = 1'b1;
        next_s.st      = H_IDLE;
      end
      H_KEY: if (tick) begin
        next_s.h_valid = 1'b1;
        next_s.h_data  = s.key[7:0];
        next_s.key     = {8'h0, s.key[63:8]};
        next_s.kcnt    = s.kcnt + 3'h1;
        if (s.kcnt == 3'(KEY_BYTES - 1)) begin
          next_s.st = H_POLL;
        end
      end
      H_POLL: if (tick) begin
        next_s.h_valid = 1'b1;
        next_s.h_data  = OP_CS_READ | {4'h0, CSS_STATUS};
        next_s.poll    = 1'b1;
        next_s.st      = H_WAIT;
      end
      H_WAIT: if (tick && link.d_valid) begin
        next_s.rsp_data = link.d_data;
        // a wrong key would poll forever, so the retries are bounded
        if (s.poll && !link.d_data[MPE_BIT] && s.pcnt != 8'(POLL_MAX)) begin
          next_s.pcnt = s.pcnt + 8'h1;
          next_s.st   = H_POLL;
        end else begin
          next_s.rsp_valid = 1'b1;
          next_s.done      = 1'b1;
          next_s.st        = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: H_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign cmd_ready    = s.st == H_IDLE;
  assign link.h_valid = s.h_valid;
  assign link.h_data  = s.h_data;
  assign link.h_break = s.h_break;
  assign rsp_valid    = s.rsp_valid;
  assign rsp_data     = s.rsp_data;
  assign done         = s.done;
endmodule
`default_nettype wire

// ### spd_device.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - one opcode byte, one operand, key eight
// - indirect load via pointer, optional post-increment
// - indirect store via pointer, optional post-increment
// - pointer store writes byte chosen by bit0
// - programmer loads pointer before indirect access
// - io read uses six-bit opcode address
// - io write uses six-bit opcode address
// - control space read by low four bits
// - control space write by low four bits
// - key opcode followed by eight key bytes
// - programming enabled only by matching key
// - programmer polls status until enabled or POLL_MAX retries
// - writing zero to enable bit disables
// - reads answered by device, writes by programmer
// - enable flag status bit one, resets zero
// - exception aborts, wait break, then idle; pointer, enable flag and guard time keep their values
module spd_device
  import spd_pkg::*;
#(
  parameter logic [7:0] IDENT = IDENT_DEFAULT
) (
  input  wire logic        rstn,
  spd_link_if.dev          link,
  input  wire logic        link_fault,
  output logic [15:0]      ds_addr,
  output logic             ds_re,
  output logic             ds_we,
  input  wire logic [7:0]  ds_rdata,
  output logic [5:0]       io_addr,
  output logic             io_re,
  output logic             io_we,
  input  wire logic [7:0]  io_rdata,
  output logic [7:0]       wdata,
  output logic             mem_prog_enabled,
  output logic [2:0]       guard_time,
  output logic             in_error
);
  typedef enum {S_IDLE, S_WAIT, S_CAPT, S_OPND, S_KEY, S_ERR} spd_dstate_type;

  typedef struct packed {
    spd_dstate_type st;
    logic [7:0]     op;
    logic [15:0]    ptr;
    logic [63:0]    key;
    logic [2:0]     kcnt;
    logic           mpe;
    logic [2:0]     gt;
    logic [15:0]    ds_addr;
    logic [5:0]     io_addr;
    logic [7:0]     wdata;
    logic           ds_re;
    logic           ds_we;
    logic           io_re;
    logic           io_we;
    logic           d_valid;
    logic [7:0]     d_data;
  } spd_dev_type;

  spd_dev_type  s;
  spd_dev_type  next_s;
  spd_kind_type kind;
  logic [63:0]  key_next;

  function automatic logic [7:0] css_read(input logic [3:0] a, input logic m, input logic [2:0] g);
    logic [7:0] v;
    v = 8'h0;
    if (a == CSS_STATUS) v[MPE_BIT] = m;
    if (a == CSS_PHY_CTRL) v[2:0] = g;
    if (a == CSS_IDENT) v = IDENT;
    return v;
  endfunction

  // bit two of the opcode asks for the post-increment, on loads and stores alike
  function automatic logic [15:0] step_ptr(input logic [7:0] op, input logic [15:0] p);
    logic [15:0] r;
    r = p;
    if (op[OP_INC_BIT]) r = p + 16'h1;
    return r;
  endfunction

  // the six address bits sit on both sides of the fixed bit four
  function automatic logic [5:0] io_field(input logic [7:0] op);
    return {op[6:5], op[3:0]};
  endfunction

  assign kind     = spd_decode(s.op);
  assign key_next = {link.h_data, s.key[63:8]};

  always_comb begin
    next_s         = s;
    next_s.ds_re   = 1'b0;
    next_s.ds_we   = 1'b0;
    next_s.io_re   = 1'b0;
    next_s.io_we   = 1'b0;
    next_s.d_valid = 1'b0;
    if (link_fault || (link.h_break && s.st != S_ERR)) begin
      next_s.st = S_ERR;
    end else begin
      unique case (s.st)
        S_ERR: begin
          if (link.h_break) begin
            next_s.st   = S_IDLE;
            next_s.kcnt = 3'h0;
          end
        end
        S_IDLE: begin
          if (link.h_valid) begin
            next_s.op      = link.h_data;
            next_s.kcnt    = 3'h0;
            next_s.ds_addr = s.ptr;
            next_s.io_addr = io_field(link.h_data);
            unique case (spd_decode(link.h_data))
              K_LOAD: begin
                next_s.ds_re = 1'b1;
                next_s.st    = S_WAIT;
              end
              K_IO_RD: begin
                next_s.io_re = 1'b1;
                next_s.st    = S_WAIT;
              end
              K_CS_RD: next_s.st = S_WAIT;
              K_STORE, K_PTR, K_IO_WR, K_CS_WR: next_s.st = S_OPND;
              K_KEY: next_s.st = S_KEY;
              K_BAD: next_s.st = S_ERR;
            endcase
          end
        end
        // spare cycle: the memories answer on the first edge after the strobe, too late to be captured at that edge
        S_WAIT: next_s.st = S_CAPT;
        S_CAPT: begin
          next_s.d_valid = 1'b1;
          next_s.st      = S_IDLE;
          unique case (kind)
            K_LOAD: begin
              next_s.d_data = ds_rdata;
              next_s.ptr    = step_ptr(s.op, s.ptr);
            end
            K_IO_RD: next_s.d_data = io_rdata;
            default: next_s.d_data = css_read(s.op[3:0], s.mpe, s.gt);
          endcase
        end
        S_OPND: begin
          if (link.h_valid) begin
            next_s.wdata = link.h_data;
            next_s.st    = S_IDLE;
            unique case (kind)
              K_STORE: begin
                next_s.ds_we = 1'b1;
                next_s.ptr   = step_ptr(s.op, s.ptr);
              end
              K_PTR: begin
                if (s.op[0]) next_s.ptr[15:8] = link.h_data;
                else next_s.ptr[7:0] = link.h_data;
              end
              K_IO_WR: next_s.io_we = 1'b1;
              default: begin
                if (s.op[3:0] == CSS_STATUS && !link.h_data[MPE_BIT]) begin
                  next_s.mpe = 1'b0;
                end
                if (s.op[3:0] == CSS_PHY_CTRL) begin
                  next_s.gt = link.h_data[2:0];
                end
              end
            endcase
          end
        end
        S_KEY: begin
          if (link.h_valid) begin
            next_s.key  = key_next;
            next_s.kcnt = s.kcnt + 3'h1;
            if (s.kcnt == 3'(KEY_BYTES - 1)) begin
              next_s.st = S_IDLE;
              // a wrong key leaves the flag as it was
              if (key_next == PROG_KEY) next_s.mpe = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // whole device runs on the link clock; no second domain at this end
  always_ff @(posedge link.link_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: S_IDLE, gt: GUARD_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.d_valid     = s.d_valid;
  assign link.d_data      = s.d_data;
  assign ds_addr          = s.ds_addr;
  assign ds_re            = s.ds_re;
  assign ds_we            = s.ds_we;
  assign io_addr          = s.io_addr;
  assign io_re            = s.io_re;
  assign io_we            = s.io_we;
  assign wdata            = s.wdata;
  assign mem_prog_enabled = s.mpe;
  assign guard_time       = s.gt;
  assign in_error         = s.st == S_ERR;
endmodule
`default_nettype wire

// ### spd_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module spd_assertions
  import spd_pkg::*;
(
  input wire logic       rstn,
  input wire logic       link_clk,
  input wire logic       h_valid,
  input wire logic [7:0] h_data,
  input wire logic       h_break,
  input wire logic       d_valid,
  input wire logic       link_fault,
  input wire logic       ds_re,
  input wire logic       ds_we,
  input wire logic       io_we,
  input wire logic [7:0] wdata,
  input wire logic       mem_prog_enabled
);
  // shadow framing: tells opcode bytes from operand bytes
  logic [3:0]  owe;
  logic        err;
  logic [7:0]  lop;
  logic [55:0] kbuf;
  logic        op;
  logic        opd;
  logic        rd;
  logic        wr;
  logic        key_ok;

  assign op     = h_valid && owe == 4'h0 && !err;
  assign opd    = h_valid && owe != 4'h0 && !err;
  assign rd     = op && (h_data == OP_LOAD || h_data == OP_LOAD_INC ||
                  (h_data & OP_IO_MASK) == OP_IO_READ || (h_data & OP_CS_MASK) == OP_CS_READ);
  assign wr     = op && (h_data == OP_STORE || h_data == OP_STORE_INC || (h_data & OP_PTR_MASK) == OP_PTR ||
                  (h_data & OP_IO_MASK) == OP_IO_WRITE || (h_data & OP_CS_MASK) == OP_CS_WRITE);
  // first key byte ends up least significant
  assign key_ok = opd && owe == 4'h1 && lop == OP_KEY && {h_data, kbuf} == PROG_KEY;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      owe  <= 4'h0;
      err  <= 1'b0;
      lop  <= 8'h00;
      kbuf <= 56'h0;
    end else if (link_fault) begin
      err <= 1'b1;
      owe <= 4'h0;
    end else if (h_break) begin
      err <= !err;
      owe <= 4'h0;
    end else if (op) begin
      lop <= h_data;
      owe <= (h_data == OP_KEY) ? 4'h8 : (wr ? 4'h1 : 4'h0);
      err <= !(rd || wr || h_data == OP_KEY);
    end else if (opd) begin
      owe  <= owe - 4'h1;
      kbuf <= {h_data, kbuf[55:8]};
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rstn);

  a_read_reply: assert property (rd |-> ##3 d_valid)
    else $error("read opcode got no reply");
  a_reply_origin: assert property (d_valid |-> $past(rd, 3))
    else $error("reply without a read opcode");
  a_reply_single: assert property (d_valid |=> !d_valid)
    else $error("reply longer than one cycle");
  a_ds_fetch: assert property (rd && h_data[7:4] == 4'h2 |=> ds_re ##1 !ds_re)
    else $error("indirect load did not fetch once");
  a_ds_store: assert property (opd && owe == 4'h1 && (lop == OP_STORE || lop == OP_STORE_INC)
    |=> ds_we && wdata == $past(h_data))
    else $error("indirect store did not write operand");
  a_io_store: assert property (opd && owe == 4'h1 && (lop & OP_IO_MASK) == OP_IO_WRITE
    |=> io_we && wdata == $past(h_data))
    else $error("io write did not write operand");
  a_key_accept: assert property (key_ok |=> mem_prog_enabled)
    else $error("matching key did not enable");
  a_enable_cause: assert property ($rose(mem_prog_enabled) |-> $past(key_ok))
    else $error("enable rose without matching key");
  a_enable_clear: assert property (opd && owe == 4'h1 && lop == {OP_CS_WRITE[7:4], CSS_STATUS}
    && !h_data[MPE_BIT] |=> !mem_prog_enabled)
    else $error("status write of zero did not disable");
  a_error_quiet: assert property (err |-> !ds_we && !io_we && !d_valid)
    else $error("activity while in error state");
endmodule
`default_nettype wire

// ### serial_prog_instr_decoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_prog_instr_decoder_tb_top
  import spd_pkg::*;
;
  typedef struct packed {logic [7:0] op; logic [7:0] od; logic [7:0] exp; logic rd;} spd_row_type;
  logic        mclk, rstn, cmd_valid, cmd_ready, cmd_break, rsp_valid, done, link_fault;
  logic        ds_re, ds_we, io_re, io_we, mem_prog_enabled, in_error;
  logic [7:0]  cmd_opcode, cmd_operand, rsp_data, ds_rdata, io_rdata, wdata;
  logic [63:0] cmd_key;
  logic [15:0] ds_addr;
  logic [5:0]  io_addr;
  logic [2:0]  guard_time;
  logic        rsp_seen;
  logic [7:0]  ds_mem [256];
  logic [7:0]  io_mem [64];
  int          err_count, comparisons;
  spd_row_type rows [16] = '{
    '{8'h68, 8'h34, 8'h00, 1'b0}, '{8'h69, 8'h01, 8'h00, 1'b0}, '{8'h60, 8'ha5, 8'h00, 1'b0},
    '{8'h20, 8'h00, 8'ha5, 1'b1}, '{8'h64, 8'h3c, 8'h00, 1'b0}, '{8'h60, 8'h77, 8'h00, 1'b0},
    '{8'h24, 8'h00, 8'h77, 1'b1}, '{8'h20, 8'h00, 8'hc8, 1'b1}, '{8'hbf, 8'h5e, 8'h00, 1'b0},
    '{8'h3f, 8'h00, 8'h5e, 1'b1}, '{8'h70, 8'h00, 8'hb0, 1'b1}, '{8'hc2, 8'h05, 8'h00, 1'b0},
    '{8'h82, 8'h00, 8'h05, 1'b1}, '{8'h8f, 8'h00, IDENT_DEFAULT, 1'b1},
    '{8'h81, 8'h00, 8'h00, 1'b1}, '{8'h80, 8'h00, 8'h00, 1'b1}};

  spd_link_if lnk();
  spd_host #(.POLL_MAX(3)) u_spd_host (.mclk(mclk), .rstn(rstn), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_break(cmd_break), .cmd_opcode(cmd_opcode), .cmd_operand(cmd_operand),
    .cmd_key(cmd_key), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done));
  spd_device u_spd_device (.rstn(rstn), .link(lnk), .link_fault(link_fault), .ds_addr(ds_addr),
    .ds_re(ds_re), .ds_we(ds_we), .ds_rdata(ds_rdata), .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_rdata(io_rdata), .wdata(wdata), .mem_prog_enabled(mem_prog_enabled), .guard_time(guard_time),
    .in_error(in_error));
  spd_assertions u_spd_assertions (.rstn(rstn), .link_clk(lnk.link_clk), .h_valid(lnk.h_valid),
    .h_data(lnk.h_data), .h_break(lnk.h_break), .d_valid(lnk.d_valid), .link_fault(link_fault),
    .ds_re(ds_re), .ds_we(ds_we), .io_we(io_we), .wdata(wdata), .mem_prog_enabled(mem_prog_enabled));

  initial begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  // both pointer bytes fold into the index, so a lost high byte shows up
  always @(posedge lnk.link_clk) begin
    if (ds_re) ds_rdata <= ds_mem[ds_addr[7:0] ^ ds_addr[15:8]];
    if (ds_we) ds_mem[ds_addr[7:0] ^ ds_addr[15:8]] <= wdata;
    if (io_re) io_rdata <= io_mem[io_addr];
    if (io_we) io_mem[io_addr] <= wdata;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // host is idle whenever this is entered, so it takes the command at the first edge after cmd_valid is raised
  task automatic cmd(input logic b, input logic [7:0] op, input logic [7:0] od, input logic [63:0] k);
    int n;
    @(posedge mclk);
    #1 {cmd_valid, cmd_break, cmd_opcode, cmd_operand, cmd_key} = {1'b1, b, op, od, k};
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
    check(cmd_ready, 0);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1 n++;
    end
    rsp_seen = rsp_valid;
    check(n >= 5000, 0);
    // last byte leaves at a falling edge and is taken at the next rising one
    repeat (2) @(posedge lnk.link_clk);
    #1;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    results();
  end

  initial begin
    {rstn, cmd_valid, cmd_break, cmd_opcode, cmd_operand, cmd_key, link_fault} = '0;
    {err_count, comparisons} = '0;
    for (int i = 0; i < 256; i++) ds_mem[i] = ~i[7:0];
    for (int i = 0; i < 64; i++) io_mem[i] = {2'b10, i[5:0]};
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    check({mem_prog_enabled, in_error, guard_time, cmd_ready}, 1);
    for (int i = 0; i < 16; i++) begin
      cmd(1'b0, rows[i].op, rows[i].od, 64'h0);
      if (rows[i].rd) check(rsp_data, rows[i].exp);
      check(rsp_seen, rows[i].rd);
      $display("test %0d done", i);
    end
    check(guard_time, 3'h5);
    cmd(1'b0, OP_KEY, 8'h00, PROG_KEY ^ 64'h1);
    check({rsp_data[MPE_BIT], mem_prog_enabled}, 0);
    cmd(1'b0, OP_KEY, 8'h00, PROG_KEY);
    check({rsp_data, mem_prog_enabled}, 9'h005);
    cmd(1'b0, 8'hc0, 8'h02, 64'h0);
    check(mem_prog_enabled, 1);
    cmd(1'b0, 8'hc0, 8'hfd, 64'h0);
    check(mem_prog_enabled, 0);
    $display("test key done");
    cmd(1'b0, 8'h00, 8'h00, 64'h0);
    check(in_error, 1);
    cmd(1'b0, 8'hc2, 8'h07, 64'h0);
    cmd(1'b1, 8'h00, 8'h00, 64'h0);
    check({in_error, guard_time}, 4'h5);
    cmd(1'b1, 8'h00, 8'h00, 64'h0);
    check(in_error, 1);
    cmd(1'b1, 8'h00, 8'h00, 64'h0);
    check(in_error, 0);
    $display("test error done");
    @(posedge lnk.link_clk);
    #1 link_fault = 1'b1;
    @(posedge lnk.link_clk);
    #1 link_fault = 1'b0;
    check(in_error, 1);
    cmd(1'b1, 8'h00, 8'h00, 64'h0);
    cmd(1'b0, 8'h8f, 8'h00, 64'h0);
    check({in_error, rsp_data}, {1'b0, IDENT_DEFAULT});
    $display("test fault done");
    cmd(1'b0, OP_KEY, 8'h00, PROG_KEY);
    check(mem_prog_enabled, 1);
    @(posedge mclk);
    #1 rstn = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    check({mem_prog_enabled, in_error, guard_time, cmd_ready}, 1);
    cmd(1'b0, OP_LOAD, 8'h00, 64'h0);
    check(rsp_data, 8'hff);
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
